// ==== src/sccc_pkg.sv ====
package sccc_pkg;
    // ************************************************
    // Register offsets (byte addresses)
    // ************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00; // Clocking, run and stagger
    localparam logic [7:0] OFS_TBA = 8'h04; // time_base_a count
    localparam logic [7:0] OFS_RELA = 8'h08; // time_base_a reload
    localparam logic [7:0] OFS_TBB = 8'h0c; // time_base_b count
    localparam logic [7:0] OFS_RELB = 8'h10; // time_base_b reload
    localparam logic [7:0] OFS_STAT = 8'h14; // Sticky events, write one to clear
    localparam logic [7:0] OFS_MASK = 8'h18; // Interrupt mask, same layout
    localparam logic [7:0] OFS_PINS = 8'h1c; // Synchronised pins and pin latches
    localparam logic [7:0] OFS_VAL = 8'h40; // Channel values, one word each
    localparam logic [7:0] OFS_CFG = 8'h80; // Channel configs, one word each
    // ************************************************
    // Field layout
    // ************************************************
    localparam int NCH = 16; // Channels
    localparam int CTRL_W = 13; // Control register width
    localparam int CTRL_STRIDE = 5; // Per-timer field group
    localparam int CTRL_PS = 0; // Prescaler select, 3 bits
    localparam int CTRL_SRC = 3; // Clock source, 2 bits
    localparam int CTRL_RUN = 10; // Run bit of timer a, b at +1
    localparam int CTRL_STAG = 12; // Staggered operation
    localparam int CFG_W = 8; // Channel config width
    localparam int CFG_TSEL = 0; // 0 time_base_a, 1 time_base_b
    localparam int CFG_MODE = 1; // Mode, 3 bits
    localparam int CFG_EDGE = 4; // Rising at +0, falling at +1
    localparam int CFG_DBL = 6; // Double register, low half only
    localparam int CFG_ONCE = 7; // Single event
    localparam int STAT_W = NCH + 2; // Channels then two overflows
    localparam int STAT_OVF = NCH; // time_base_a overflow, b at +1
    // ************************************************
    // Reset values and timing
    // ************************************************
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
    localparam logic [15:0] TB_RST = 16'h0000;
    localparam logic [STAT_W-1:0] MASK_RST = 18'h00000;
    localparam int STAGGER_CYCLES = 8; // Step spacing when staggered
    // ************************************************
    // Enumerations
    // ************************************************
    typedef enum logic [2:0] {
        CM_OFF = 3'b000,
        CM_CAPT = 3'b001,
        CM_CMP0 = 3'b010,
        CM_CMP1 = 3'b011,
        CM_CMP2 = 3'b100,
        CM_CMP3 = 3'b101
    } sccc_mode_e;
    typedef enum logic [1:0] {
        SRC_PRESC = 2'b00,
        SRC_UPSTR = 2'b01,
        SRC_EXT = 2'b10
    } sccc_src_e;
endpackage : sccc_pkg

// ==== src/sccc_top.sv ====
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module sccc_top
    import sccc_pkg::*;
#(
    parameter int PRE_W = 8
) (
    input logic clk,
    input logic resetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input logic upstreamTick,
    input logic extCount,
    input logic [NCH-1:0] ccPinIn,
    output logic [NCH-1:0] ccPinOut,
    output logic [NCH-1:0] ccPinOen,
    output logic irq
);
    localparam int HALF = NCH / 2;
    localparam int STG_W = $clog2(STAGGER_CYCLES);

    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ************************************************
    // Helpers
    // ************************************************
    // Prescaler tick every 2**sel clocks
    function automatic logic presc_tick(input logic [PRE_W-1:0] cnt, input logic [2:0] sel);
        logic [PRE_W-1:0] m;
        m = ~({PRE_W{1'b1}} << sel);
        return (cnt & m) == m;
    endfunction : presc_tick

    function automatic logic modeIs(input logic [CFG_W-1:0] c, input sccc_mode_e m);
        return c[CFG_MODE +: 3] == m;
    endfunction : modeIs

    // Word address hits channel slot i of a channel bank
    function automatic logic hitCh(input logic [7:0] a, input logic [7:0] base, input int i);
        return a[7:6] == base[7:6] && a[5:2] == 4'(i);
    endfunction : hitCh

    // ************************************************
    // Input synchronisers
    // ************************************************
    logic [NCH-1:0] pinS1, pinS2, pinS3; // Stage 3 only for edges
    logic [2:0] extS; // External count sync and edge
    logic [NCH-1:0] rise, fall;
    logic extTick;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinS1 <= '0;
            pinS2 <= '0;
            pinS3 <= '0;
            extS <= '0;
        end else begin
            pinS1 <= ccPinIn;
            pinS2 <= pinS1;
            pinS3 <= pinS2;
            extS <= {extS[1:0], extCount};
        end
    end

    // Edges use stages 2 and 3, so a level held for one clock still gives an edge
    assign rise = pinS2 & ~pinS3;
    assign fall = ~pinS2 & pinS3;
    assign extTick = extS[1] & ~extS[2];

    // ************************************************
    // AHB-Lite slave
    // ************************************************
    logic apSel; // Address phase taken
    logic wrPend, rdPend; // Data phase pending
    logic [7:0] apAddr; // Only low byte decoded, upper bits alias
    logic [31:0] rdData;

    assign apSel = hsel && htrans[1] && hready;

    // Reads take one wait state so that a write just before is seen
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            apAddr <= 8'h00;
            wrPend <= 1'b0;
            rdPend <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (apSel) begin
                apAddr <= haddr[7:0];
                wrPend <= hwrite;
                rdPend <= !hwrite;
                hreadyout <= hwrite;
            end else begin
                wrPend <= 1'b0;
                rdPend <= 1'b0;
                hreadyout <= 1'b1;
            end
            if (rdPend) begin
                hrdata <= rdData;
            end
        end
    end

    // ************************************************
    // Registers and write decode
    // ************************************************
    logic [CTRL_W-1:0] ctrl; // Timer clocking control
    logic [15:0] tb [2]; // Time base counters
    logic [15:0] rel [2]; // Reload values
    logic [15:0] val [NCH]; // Channel capture/compare values
    logic [CFG_W-1:0] cfg [NCH]; // Channel configs
    logic [STAT_W-1:0] stat, mask, next_stat;
    logic [1:0] tbWr, relWr;
    logic [NCH-1:0] valWr, cfgWr;

    always_comb begin
        tbWr[0] = wrPend && apAddr == OFS_TBA;
        tbWr[1] = wrPend && apAddr == OFS_TBB;
        relWr[0] = wrPend && apAddr == OFS_RELA;
        relWr[1] = wrPend && apAddr == OFS_RELB;
        for (int i = 0; i < NCH; i++) begin
            valWr[i] = wrPend && hitCh(apAddr, OFS_VAL, i);
            cfgWr[i] = wrPend && hitCh(apAddr, OFS_CFG, i);
        end
    end

    // Read mux, unmapped words read zero
    always_comb begin
        rdData = 32'h0000_0000;
        if (apAddr[7:6] == OFS_VAL[7:6]) begin
            rdData = {16'h0000, val[apAddr[5:2]]};
        end else if (apAddr[7:6] == OFS_CFG[7:6]) begin
            rdData = {24'h000000, cfg[apAddr[5:2]]};
        end else begin
            case (apAddr)
                OFS_CTRL: rdData = 32'(ctrl);
                OFS_TBA: rdData = {16'h0000, tb[0]};
                OFS_RELA: rdData = {16'h0000, rel[0]};
                OFS_TBB: rdData = {16'h0000, tb[1]};
                OFS_RELB: rdData = {16'h0000, rel[1]};
                OFS_STAT: rdData = 32'(stat);
                OFS_MASK: rdData = 32'(mask);
                OFS_PINS: rdData = {pinS2, ccPinOut};
                default: rdData = 32'h0000_0000;
            endcase
        end
    end

    // Control and mask
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= CTRL_RST;
            mask <= MASK_RST;
        end else begin
            if (wrPend && apAddr == OFS_CTRL) begin
                ctrl <= hwdata[CTRL_W-1:0];
            end
            if (wrPend && apAddr == OFS_MASK) begin
                mask <= hwdata[STAT_W-1:0];
            end
        end
    end

    // ************************************************
    // Time bases
    // ************************************************
    logic [PRE_W-1:0] presc; // Shared free-running prescaler
    logic [STG_W-1:0] stag; // Stagger phase
    logic stagOk;
    logic [1:0] srcTick, step, ovf;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            presc <= '0;
            stag <= '0;
        end else begin
            presc <= presc + 1'b1;
            stag <= stag + 1'b1;
        end
    end

    assign stagOk = !ctrl[CTRL_STAG] || stag == '0;

    always_comb begin
        for (int t = 0; t < 2; t++) begin
            case (ctrl[t*CTRL_STRIDE+CTRL_SRC +: 2])
                SRC_PRESC: srcTick[t] = presc_tick(presc, ctrl[t*CTRL_STRIDE+CTRL_PS +: 3]);
                SRC_UPSTR: srcTick[t] = upstreamTick;
                SRC_EXT: srcTick[t] = (t == 0) && extTick;
                default: srcTick[t] = 1'b0;
            endcase
            step[t] = ctrl[CTRL_RUN+t] && stagOk && srcTick[t];
            ovf[t] = step[t] && tb[t] == 16'hffff;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int t = 0; t < 2; t++) begin
                tb[t] <= TB_RST;
                rel[t] <= TB_RST;
            end
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (relWr[t]) begin
                    rel[t] <= hwdata[15:0];
                end
                if (tbWr[t]) begin
                    tb[t] <= hwdata[15:0];
                end else if (ovf[t]) begin
                    tb[t] <= rel[t];
                end else if (step[t]) begin
                    tb[t] <= tb[t] + 16'h0001;
                end
            end
        end
    end

    // ************************************************
    // Channel events
    // ************************************************
    logic [15:0] selTb [NCH]; // Assigned timer value
    logic [NCH-1:0] selStep, selOvf, match, capt, cmpEv;
    logic [NCH-1:0] spent, armed; // Single-event and per-period state

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            selTb[i] = tb[cfg[i][CFG_TSEL]];
            selStep[i] = step[cfg[i][CFG_TSEL]];
            selOvf[i] = ovf[cfg[i][CFG_TSEL]];
            match[i] = selStep[i] && selTb[i] == val[i] && !spent[i];
            capt[i] = 1'b0;
            cmpEv[i] = 1'b0;
            unique case (cfg[i][CFG_MODE +: 3])
                CM_OFF: cmpEv[i] = 1'b0;
                CM_CAPT: capt[i] = (rise[i] && cfg[i][CFG_EDGE]) || (fall[i] && cfg[i][CFG_EDGE+1]);
                CM_CMP0, CM_CMP1: cmpEv[i] = match[i];
                CM_CMP2, CM_CMP3: cmpEv[i] = match[i] && armed[i];
                default: cmpEv[i] = 1'b0;
            endcase
        end
    end

    // Armed again by overflow; overflow wins as the match closes the old period
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spent <= '0;
            armed <= '1;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (cmpEv[i] && cfg[i][CFG_ONCE]) begin
                    spent[i] <= 1'b1;
                end else if (cfgWr[i]) begin
                    spent[i] <= 1'b0;
                end
                if (selOvf[i]) begin
                    armed[i] <= 1'b1;
                end else if (cmpEv[i]) begin
                    armed[i] <= 1'b0;
                end
            end
        end
    end

    // Values and configs; a capture wins over a software write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NCH; i++) begin
                val[i] <= TB_RST;
                cfg[i] <= CFG_RST;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (capt[i]) begin
                    val[i] <= selTb[i];
                end else if (valWr[i]) begin
                    val[i] <= hwdata[15:0];
                end
                if (cfgWr[i]) begin
                    cfg[i] <= hwdata[CFG_W-1:0];
                end
            end
        end
    end

    // ************************************************
    // Pin drivers
    // ************************************************
    logic [NCH-1:0] tog, setP, clrP, drive;

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            tog[i] = cmpEv[i] && modeIs(cfg[i], CM_CMP1);
            // set on match, clear on overflow
            setP[i] = cmpEv[i] && modeIs(cfg[i], CM_CMP3);
            clrP[i] = selOvf[i] && modeIs(cfg[i], CM_CMP3);
            // pin is output only when comparing to it
            drive[i] = modeIs(cfg[i], CM_CMP1) || modeIs(cfg[i], CM_CMP3);
        end
        for (int i = 0; i < HALF; i++) begin
            if (cfg[i][CFG_DBL]) begin
                tog[i] = cmpEv[i] || cmpEv[i+HALF];
                setP[i] = 1'b0;
                clrP[i] = 1'b0;
                drive[i] = 1'b1;
                tog[i+HALF] = 1'b0;
                setP[i+HALF] = 1'b0;
                clrP[i+HALF] = 1'b0;
                drive[i+HALF] = 1'b0;
            end
        end
    end

    // Set wins when match and overflow coincide
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ccPinOut <= '0;
            ccPinOen <= '1;
        end else begin
            ccPinOen <= ~drive;
            for (int i = 0; i < NCH; i++) begin
                if (tog[i]) begin
                    ccPinOut[i] <= ~ccPinOut[i];
                end else if (setP[i]) begin
                    ccPinOut[i] <= 1'b1;
                end else if (clrP[i]) begin
                    ccPinOut[i] <= 1'b0;
                end
            end
        end
    end

    // ************************************************
    // Interrupt status
    // ************************************************
    // New events win over a write-one clear in the same cycle
    always_comb begin
        next_stat = stat;
        if (wrPend && apAddr == OFS_STAT) begin
            next_stat = stat & ~hwdata[STAT_W-1:0];
        end
        next_stat = next_stat | {ovf, capt | cmpEv};
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat <= '0;
            irq <= 1'b0;
        end else begin
            stat <= next_stat;
            irq <= |(next_stat & mask);
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    sequence s_m3Match;
        cmpEv[3] && modeIs(cfg[3], CM_CMP3) && !cfg[3][CFG_DBL];
    endsequence
    sequence s_m3Ovf;
        selOvf[3] && !cmpEv[3] && modeIs(cfg[3], CM_CMP3) && !cfg[3][CFG_DBL];
    endsequence

    a_stagger_step: assert property (
        ctrl[CTRL_STAG] && step[0] |=> !step[0] [*7]) else $error("stagger step too soon");
    a_tb_reload: assert property (
        ovf[0] && !tbWr[0] |=> tb[0] == $past(rel[0])) else $error("reload not taken");
    a_tb_count: assert property (
        step[0] && !ovf[0] && !tbWr[0] |=> tb[0] == 16'($past(tb[0]) + 16'h0001)) else $error("count wrong");
    a_mode0_pin: assert property (
        modeIs(cfg[0], CM_CMP0) && !cfg[0][CFG_DBL] |=> $stable(ccPinOut[0])) else $error("mode 0 moved pin");
    a_mode1_toggle: assert property (
        cmpEv[1] && modeIs(cfg[1], CM_CMP1) |=> ccPinOut[1] != $past(ccPinOut[1])) else $error("no toggle");
    a_mode2_once: assert property (
        cmpEv[2] && modeIs(cfg[2], CM_CMP2) && !selOvf[2] |=> !armed[2]) else $error("mode 2 still armed");
    a_mode3_set: assert property (
        s_m3Match |=> ccPinOut[3]) else $error("mode 3 pin not set");
    a_mode3_clear: assert property (
        s_m3Ovf |=> !ccPinOut[3]) else $error("mode 3 pin not cleared");
    a_single_event: assert property (
        cmpEv[4] && cfg[4][CFG_ONCE] |=> spent[4] && !cmpEv[4]) else $error("repeat event");
    a_capture_value: assert property (
        capt[6] |=> val[6] == $past(selTb[6]) && stat[6]) else $error("capture lost");
endmodule : sccc_top

// ==== testbench/sccc_pin_model.sv ====
`timescale 1ns/100ps
// ************************************************
// Outside world on the channel pins
// ************************************************
module sccc_pin_model
    import sccc_pkg::*;
(
    input wire logic clk,
    input wire logic [NCH-1:0] extLevel,
    input wire logic [NCH-1:0] ccPinOut,
    input wire logic [NCH-1:0] ccPinOen,
    output logic [NCH-1:0] ccPinIn
);
    logic [NCH-1:0] pendLevel = '0; // Requested level, one clock behind
    logic [NCH-1:0] heldLevel = '0; // Level actually presented on the wire

    // hold two clocks
    // A level reaches the wire only once it was asked for two clocks running,
    // so a glitch in the stimulus can never look like a capture edge
    always_ff @(posedge clk) begin
        pendLevel <= extLevel;
        if (pendLevel == extLevel) begin
            heldLevel <= pendLevel;
        end
    end

    // pin direction
    // Low enable: the device owns the wire, our own level is released
    assign ccPinIn = (ccPinOen & heldLevel) | (~ccPinOen & ccPinOut);
endmodule : sccc_pin_model

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
    import sccc_pkg::*;
    // ************************************************
    // Signals
    // ************************************************
    logic clk, resetn, hsel, hwrite, upstreamTick, extCount, rdPhase;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, irq;
    logic [NCH-1:0] ccPinIn, ccPinOut, ccPinOen, extLevel;
    logic [31:0] expQ[$], mskQ[$]; // Expected read data and the bits that matter
    logic [15:0] tbVal, tbVal2; // Random timer values for capture
    int n_fail, cmp_count;
    // Compare channels: cmp0, cmp1, cmp2, cmp3, cmp1 single, double owner, its partner
    localparam int CH[7] = '{0, 1, 2, 3, 4, 5, 13};
    localparam logic [7:0] CFG[7] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h86, 8'h44, 8'h04};
    localparam logic [15:0] VAL[7] = '{16'hfff4, 16'hfff4, 16'hfff4, 16'hfff4, 16'hfff4, 16'hfff2, 16'hfffa};
    localparam logic [7:0] RST_ADDR[10] = '{OFS_CTRL, OFS_TBA, OFS_RELA, OFS_TBB, OFS_RELB,
                                            OFS_STAT, OFS_MASK, OFS_PINS, OFS_CFG, 8'h3c};

    sccc_top #(.PRE_W(8)) sccc_top_inst (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .upstreamTick(upstreamTick),
        .extCount(extCount), .ccPinIn(ccPinIn), .ccPinOut(ccPinOut), .ccPinOen(ccPinOen), .irq(irq));
    sccc_pin_model sccc_pin_model_inst (.clk(clk), .extLevel(extLevel), .ccPinOut(ccPinOut),
        .ccPinOen(ccPinOen), .ccPinIn(ccPinIn));

    // ************************************************
    // Helpers
    // ************************************************
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // One comparison, counted, reported at once on mismatch
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Verdict and end of run, shared with the watchdog
    task final_report();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    // Single AHB-Lite transfer; a read notes its expectation as the data phase opens
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        haddr <= {24'h000000, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        if (wr) begin
            hwdata <= d;
        end else begin
            expQ.push_back(d);
            mskQ.push_back(m);
            rdPhase <= 1'b1;
        end
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rdPhase <= 1'b0;
    endtask : ahb

    // Timer steps from the upstream timer, then let the events land
    task tick(input int n);
        repeat (n) begin
            @(posedge clk);
            upstreamTick <= 1'b1;
            @(posedge clk);
            upstreamTick <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask : tick

    // Read monitor: oldest note against the data seen at completion
    always @(posedge clk) begin
        if (rdPhase === 1'b1 && hreadyout === 1'b1) begin
            chk("hrdata", expQ[0] & mskQ[0], hrdata & mskQ[0]);
            chk("hresp", 32'h0, 32'(hresp));
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
        end
    end

    // Watchdog, far beyond the roughly 400 cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        {resetn, hsel, hwrite, upstreamTick, extCount, rdPhase} = '0;
        {haddr, hwdata, htrans, hsize, extLevel} = '0;
        void'($urandom(91));
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk("oen reset", 32'h0000ffff, 32'(ccPinOen));
        chk("irq reset", 32'h0, 32'(irq));
        @(posedge clk);
        resetn <= 1'b1;
        foreach (RST_ADDR[i]) ahb(1'b0, RST_ADDR[i], 32'h0, 32'hffffffff);
        // Compare setup on time_base_a, period of 16 steps
        ahb(1'b1, OFS_RELA, 32'h0000fff0, 32'h0);
        ahb(1'b1, OFS_TBA, 32'h0000fff0, 32'h0);
        foreach (CH[i]) begin
            ahb(1'b1, 8'(int'(OFS_CFG) + 4 * CH[i]), 32'(CFG[i]), 32'h0);
            ahb(1'b1, 8'(int'(OFS_VAL) + 4 * CH[i]), 32'(VAL[i]), 32'h0);
        end
        ahb(1'b1, OFS_MASK, 32'h00000001, 32'h0);
        ahb(1'b1, OFS_CTRL, 32'h00000408, 32'h0);
        @(negedge clk);
        chk("oen", 32'h0000ffc5, 32'(ccPinOen));
        tick(8);
        ahb(1'b0, OFS_PINS, 32'h0000003a, 32'h0000ffff);
        ahb(1'b0, OFS_STAT, 32'h0000003f, 32'h0003ffff);
        @(negedge clk);
        chk("irq", 32'h1, 32'(irq));
        chk("pin out", 32'h0000003a, 32'(ccPinOut));
        ahb(1'b1, OFS_STAT, 32'h00000001, 32'h0);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("irq masked", 32'h0, 32'(irq));
        ahb(1'b1, OFS_STAT, 32'h0003ffff, 32'h0);
        tick(8);
        ahb(1'b0, OFS_PINS, 32'h00000012, 32'h0000ffff);
        ahb(1'b0, OFS_STAT, 32'h00012000, 32'h0003ffff);
        ahb(1'b0, OFS_TBA, 32'h0000fff0, 32'h0000ffff);
        ahb(1'b1, OFS_STAT, 32'h0003ffff, 32'h0);
        tick(8);
        ahb(1'b0, OFS_PINS, 32'h00000038, 32'h0000ffff);
        ahb(1'b0, OFS_STAT, 32'h0000002f, 32'h0003ffff);
        // Second match inside one period: cmp0 fires again, cmp2 stays quiet
        ahb(1'b1, OFS_STAT, 32'h0003ffff, 32'h0);
        ahb(1'b1, OFS_VAL, 32'h0000fffc, 32'h0);
        ahb(1'b1, 8'(int'(OFS_VAL) + 8), 32'h0000fffc, 32'h0);
        tick(5);
        ahb(1'b0, OFS_STAT, 32'h00000001, 32'h00000005);
        ahb(1'b1, OFS_CTRL, 32'h0, 32'h0);
        // Capture: ch6 rising on b, ch7 falling on a, ch8 both on b
        tbVal = 16'($urandom());
        tbVal2 = 16'($urandom());
        ahb(1'b1, OFS_TBB, 32'(tbVal), 32'h0);
        ahb(1'b1, 8'(int'(OFS_CFG) + 24), 32'h00000013, 32'h0);
        ahb(1'b1, 8'(int'(OFS_CFG) + 28), 32'h00000022, 32'h0);
        ahb(1'b1, 8'(int'(OFS_CFG) + 32), 32'h00000033, 32'h0);
        ahb(1'b1, OFS_STAT, 32'h0003ffff, 32'h0);
        @(posedge clk);
        extLevel <= 16'h01c0;
        repeat (8) @(posedge clk);
        ahb(1'b0, 8'(int'(OFS_VAL) + 24), 32'(tbVal), 32'hffffffff);
        ahb(1'b0, 8'(int'(OFS_VAL) + 28), 32'h0, 32'hffffffff);
        ahb(1'b0, 8'(int'(OFS_VAL) + 32), 32'(tbVal), 32'hffffffff);
        ahb(1'b0, OFS_STAT, 32'h00000140, 32'h000001c0);
        ahb(1'b1, OFS_TBB, 32'(tbVal2), 32'h0);
        @(posedge clk);
        extLevel <= 16'h0000;
        repeat (8) @(posedge clk);
        ahb(1'b0, 8'(int'(OFS_VAL) + 24), 32'(tbVal), 32'hffffffff);
        ahb(1'b0, 8'(int'(OFS_VAL) + 28), 32'h0000fffd, 32'hffffffff);
        ahb(1'b0, 8'(int'(OFS_VAL) + 32), 32'(tbVal2), 32'hffffffff);
        // External count source on time_base_a
        ahb(1'b1, OFS_TBA, 32'h00000100, 32'h0);
        ahb(1'b1, OFS_CTRL, 32'h00000410, 32'h0);
        repeat (3) begin
            @(posedge clk);
            extCount <= 1'b1;
            repeat (4) @(posedge clk);
            extCount <= 1'b0;
            repeat (4) @(posedge clk);
        end
        ahb(1'b0, OFS_TBA, 32'h00000103, 32'h0000ffff);
        // Staggered prescaler steps: about 70 clocks must give fewer than 16 steps
        ahb(1'b1, OFS_TBA, 32'h00000000, 32'h0);
        ahb(1'b1, OFS_CTRL, 32'h00001400, 32'h0);
        repeat (64) @(posedge clk);
        ahb(1'b0, OFS_TBA, 32'h00000000, 32'h0000fff0);
        final_report();
    end
endmodule : tb
